// File: core/vme_cfg.svh
// Purpose: Constants for the backplane slave address decoder.
// Assumes: Included by bare name from the design files.
// Notes:   Address modifier codes, buffer window and storage sizes.
`ifndef VME_CFG_SVH
`define VME_CFG_SVH

`define AM_A24_BLT_SUP   6'h3F
`define AM_A24_SGL_SUP   6'h3D
`define AM_A24_MBLT_SUP  6'h3C
`define AM_A24_BLT_USR   6'h3B
`define AM_A24_SGL_USR   6'h39
`define AM_A24_MBLT_USR  6'h38
`define AM_CSR           6'h2F
`define AM_A32_BLT_SUP   6'h0F
`define AM_A32_SGL_SUP   6'h0D
`define AM_A32_MBLT_SUP  6'h0C
`define AM_A32_BLT_USR   6'h0B
`define AM_A32_SGL_USR   6'h09
`define AM_A32_MBLT_USR  6'h08

`define BUF_OFFSET_LIMIT 16'h1000
`define CHAIN_MID_BYTE   8'h00
`define FIFO_WIDTH       32
`define FIFO_DEPTH       32

`endif

// File: core/vme_types_pkg.sv
// Purpose: Types shared by the backplane slave address decoder.
// Assumes: Nothing.
// Notes:   Cycle kinds and the one-hot controller states.
package vme_types_pkg;

  typedef enum logic [2:0] {
    CYC_NONE, CYC_A24_SGL, CYC_A24_BLT, CYC_A24_MBLT,
    CYC_CSR, CYC_A32_SGL, CYC_A32_BLT, CYC_A32_MBLT
  } cyc_kind_t;

  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_WAIT_DS = 8'h02,
    S_REG     = 8'h04,
    S_BUF     = 8'h08,
    S_BUF2    = 8'h10,
    S_ACK     = 8'h20,
    S_PASS    = 8'h40,
    S_END     = 8'h80
  } state_t;

endpackage

// File: core/event_fifo.sv
// Purpose: Event word buffer between the converter side and the backplane.
// Assumes: One clock; both sides are logic on that clock.
// Notes:   Full and empty are exact; a full buffer holds off the writer.
`timescale 1ns/100ps
module event_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Fill side
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  // Drain side
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic [WIDTH-1:0]                out_data_out,
  output logic [$clog2(DEPTH):0]          count_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_idx];
  assign count_out     = count;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_idx] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      wr_idx <= push ? AW'(wr_idx + 1'b1) : wr_idx;
      rd_idx <= pop ? AW'(rd_idx + 1'b1) : rd_idx;
      count  <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// File: core/vme_slave_address_decode.sv
// Purpose: Backplane slave front end: modifier check, base match, beats, interrupter.
// Assumes: Backplane pins are asynchronous and pass a two-flop synchroniser.
// Notes:   Configuration comes from the module's own register bank as plain inputs.
// Function
// - Accept A24 single cycles, both privilege codes.
// - Accept A24 32-bit block transfers, both codes.
// - Accept A24 64-bit block transfers, both codes.
// - Respond to the configuration space modifier.
// - Accept A32 single cycles, both privilege codes.
// - Accept A32 32-bit block transfers, both codes.
// - Accept A32 64-bit block transfers, both codes.
// - Decode both 24-bit and 32-bit addresses.
// - Base address in 64 KB steps.
// - Source bit clear: base from rotary switches.
// - Source bit set: base from programmed registers.
// - High register gives A31-24, low gives A23-16.
// - Slot position used only in chained readout.
// - Buffer readout: single, block, chained, 32/64-bit.
// - Registers readable and writable at D16 or D32.
// - Seven-level interrupter, released by buffer reads.
// - Chain addressing only in A32 space.
// - Block and 64-bit cycles go to the buffer.
`timescale 1ns/100ps
`include "vme_cfg.svh"
module vme_slave_address_decode (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Backplane address, modifier and strobes
  input  wire logic [31:1] vme_a_in,
  output logic      [31:1] vme_a_out,
  output logic             vme_a_oe_n_out,
  input  wire logic        vme_lword_n_in,
  output logic             vme_lword_n_out,
  output logic             vme_lword_oe_n_out,
  input  wire logic [5:0]  vme_am_in,
  input  wire logic        vme_as_n_in,
  input  wire logic        vme_ds0_n_in,
  input  wire logic        vme_ds1_n_in,
  input  wire logic        vme_write_n_in,
  input  wire logic        vme_iack_n_in,
  input  wire logic        vme_iackin_n_in,
  output logic             vme_iackout_n_out,
  // Backplane data and answers
  input  wire logic [31:0] vme_d_in,
  output logic      [31:0] vme_d_out,
  output logic             vme_d_oe_n_out,
  output logic             vme_dtack_n_out,
  output logic             vme_dtack_oe_n_out,
  output logic             vme_berr_n_out,
  output logic             vme_berr_oe_n_out,
  output logic      [7:1]  vme_irq_n_out,
  output logic      [7:1]  vme_irq_oe_n_out,
  // Configuration from the module register bank
  input  wire logic        base_src_sel_in,
  input  wire logic [15:0] rotary_sw_in,
  input  wire logic [7:0]  base_high_in,
  input  wire logic [7:0]  base_low_in,
  input  wire logic [7:0]  chain_addr_in,
  input  wire logic        chain_first_in,
  input  wire logic        chain_last_in,
  input  wire logic [4:0]  slot_position_address_in,
  input  wire logic [2:0]  irq_level_in,
  input  wire logic [7:0]  irq_vector_in,
  input  wire logic [5:0]  event_trigger_in,
  // Register access port
  output logic             reg_req_out,
  output logic             reg_write_out,
  output logic             reg_wide_out,
  output logic      [15:0] reg_offset_out,
  output logic      [31:0] reg_wdata_out,
  input  wire logic        reg_ack_in,
  input  wire logic [31:0] reg_rdata_in,
  // Event words from the converter
  input  wire logic        ev_valid_in,
  output logic             ev_ready_out,
  input  wire logic [31:0] ev_data_in
);
  function automatic vme_types_pkg::cyc_kind_t am_kind(input logic [5:0] am);
    case (am)
      `AM_A24_SGL_SUP, `AM_A24_SGL_USR:   am_kind = vme_types_pkg::CYC_A24_SGL;
      `AM_A24_BLT_SUP, `AM_A24_BLT_USR:   am_kind = vme_types_pkg::CYC_A24_BLT;
      `AM_A24_MBLT_SUP, `AM_A24_MBLT_USR: am_kind = vme_types_pkg::CYC_A24_MBLT;
      `AM_CSR:                            am_kind = vme_types_pkg::CYC_CSR;
      `AM_A32_SGL_SUP, `AM_A32_SGL_USR:   am_kind = vme_types_pkg::CYC_A32_SGL;
      `AM_A32_BLT_SUP, `AM_A32_BLT_USR:   am_kind = vme_types_pkg::CYC_A32_BLT;
      `AM_A32_MBLT_SUP, `AM_A32_MBLT_USR: am_kind = vme_types_pkg::CYC_A32_MBLT;
      default:                            am_kind = vme_types_pkg::CYC_NONE;
    endcase
  endfunction

  // Chained readout words carry the slot in their top five bits.
  function automatic logic [31:0] tag_word(input logic chained, input logic [31:0] w);
    tag_word = chained ? {slot_position_address_in, w[26:0]} : w;
  endfunction

  logic [75:0] pin_raw;
  logic [75:0] pin_s1;
  logic [75:0] pin_s2;
  logic [31:1] a_s;
  logic [5:0]  am_s;
  logic [31:0] d_s;
  logic        lword_n_s, as_n_s, ds0_n_s, ds1_n_s, write_n_s, iack_n_s, iackin_n_s;

  vme_types_pkg::state_t    state;
  vme_types_pkg::state_t    next_state;
  vme_types_pkg::cyc_kind_t kind;

  logic [15:0] base_addr;
  logic        a24_kind, block_kind, mblt_kind, base_hit, offset_is_buf, base_ok;
  logic        chain_match, mcst_hit, cblt_hit, chain_hit, to_reg, to_buf;
  logic        ds_both, ds_none, trigger, beat_ok, mblt_sel, irq_mine, pop, in_ack;
  logic        claim_block, claim_mblt, claim_chain, claim_read, berr_flag, irq_active;
  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic [5:0]  fifo_count;

  // Address, modifier and strobes pass two flops before any decode looks at them.
  assign pin_raw = {vme_a_in, vme_lword_n_in, vme_am_in, vme_as_n_in, vme_ds0_n_in,
                    vme_ds1_n_in, vme_write_n_in, vme_iack_n_in, vme_iackin_n_in, vme_d_in};
  always_ff @(posedge sys_clk_in) begin
    pin_s1 <= rst_in ? {76{1'b1}} : pin_raw;
    pin_s2 <= rst_in ? {76{1'b1}} : pin_s1;
  end
  assign a_s        = pin_s2[75:45];
  assign lword_n_s  = pin_s2[44];
  assign am_s       = pin_s2[43:38];
  assign as_n_s     = pin_s2[37];
  assign ds0_n_s    = pin_s2[36];
  assign ds1_n_s    = pin_s2[35];
  assign write_n_s  = pin_s2[34];
  assign iack_n_s   = pin_s2[33];
  assign iackin_n_s = pin_s2[32];
  assign d_s        = pin_s2[31:0];

  assign kind       = am_kind(am_s);
  assign base_addr  = base_src_sel_in ? {base_high_in, base_low_in} : rotary_sw_in;
  assign a24_kind   = (kind == vme_types_pkg::CYC_A24_SGL) | (kind == vme_types_pkg::CYC_A24_BLT)
                    | (kind == vme_types_pkg::CYC_A24_MBLT) | (kind == vme_types_pkg::CYC_CSR);
  assign mblt_kind  = (kind == vme_types_pkg::CYC_A24_MBLT) | (kind == vme_types_pkg::CYC_A32_MBLT);
  assign block_kind = mblt_kind | (kind == vme_types_pkg::CYC_A24_BLT)
                    | (kind == vme_types_pkg::CYC_A32_BLT);
  // Only whole 64 KB windows are compared; the low half is the offset.
  assign base_hit   = a24_kind ? (a_s[23:16] == base_addr[7:0])
                    : (kind != vme_types_pkg::CYC_NONE) & (a_s[31:16] == base_addr);
  assign offset_is_buf = {a_s[15:1], 1'b0} < `BUF_OFFSET_LIMIT;
  // The buffer is read only, and block cycles never reach the registers.
  assign base_ok    = base_hit & (block_kind ? (offset_is_buf & write_n_s)
                                             : !(offset_is_buf & !write_n_s));

  assign chain_match = (chain_first_in | chain_last_in) & (a_s[31:24] == chain_addr_in)
                     & (a_s[23:16] == `CHAIN_MID_BYTE);
  assign mcst_hit   = chain_match & (kind == vme_types_pkg::CYC_A32_SGL) & !write_n_s;
  assign cblt_hit   = chain_match & write_n_s & (chain_first_in | !iackin_n_s)
                    & ((kind == vme_types_pkg::CYC_A32_BLT)
                    | (kind == vme_types_pkg::CYC_A32_MBLT));
  assign chain_hit  = mcst_hit | cblt_hit;
  assign to_reg     = mcst_hit | (!chain_hit & base_ok & !offset_is_buf);
  assign to_buf     = cblt_hit | (!chain_hit & base_ok & offset_is_buf);

  assign ds_both    = !ds0_n_s & !ds1_n_s;
  assign ds_none    = ds0_n_s & ds1_n_s;
  assign trigger    = !as_n_s & ds_both;
  assign mblt_sel   = (state == vme_types_pkg::S_IDLE) ? mblt_kind : claim_mblt;
  // D16 uses LWORD high; D32 needs LWORD low on an aligned word; MBLT needs LWORD low.
  assign beat_ok    = mblt_sel ? !lword_n_s : (lword_n_s | !a_s[1]);
  assign irq_mine   = irq_active & (a_s[3:1] == irq_level_in);
  assign pop        = fifo_valid & ((state == vme_types_pkg::S_BUF)
                    | (state == vme_types_pkg::S_BUF2));
  assign in_ack     = (state == vme_types_pkg::S_ACK);

  always_comb begin
    next_state = state;
    case (state)
      vme_types_pkg::S_IDLE: begin
        if (trigger && !iack_n_s) begin
          if (!iackin_n_s) begin
            next_state = irq_mine ? vme_types_pkg::S_ACK : vme_types_pkg::S_PASS;
          end
        end else if (trigger) begin
          if (beat_ok && to_reg) begin
            next_state = vme_types_pkg::S_REG;
          end else if (beat_ok && to_buf) begin
            next_state = vme_types_pkg::S_BUF;
          end else begin
            next_state = vme_types_pkg::S_END;
          end
        end
      end
      vme_types_pkg::S_WAIT_DS: begin
        if (as_n_s) begin
          next_state = vme_types_pkg::S_IDLE;
        end else if (ds_both && beat_ok) begin
          next_state = vme_types_pkg::S_BUF;
        end
      end
      vme_types_pkg::S_REG: begin
        if (reg_ack_in) begin
          next_state = vme_types_pkg::S_ACK;
        end
      end
      vme_types_pkg::S_BUF: begin
        if (fifo_valid) begin
          next_state = claim_mblt ? vme_types_pkg::S_BUF2 : vme_types_pkg::S_ACK;
        end else if (claim_chain && !chain_last_in) begin
          next_state = vme_types_pkg::S_PASS;
        end else begin
          next_state = vme_types_pkg::S_ACK;
        end
      end
      vme_types_pkg::S_BUF2: next_state = vme_types_pkg::S_ACK;
      vme_types_pkg::S_ACK: begin
        if (ds_none) begin
          next_state = (claim_block && !berr_flag && !as_n_s) ? vme_types_pkg::S_WAIT_DS
                                                              : vme_types_pkg::S_END;
        end
      end
      vme_types_pkg::S_PASS, vme_types_pkg::S_END: begin
        if (as_n_s) begin
          next_state = vme_types_pkg::S_IDLE;
        end
      end
      default: next_state = vme_types_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    state <= rst_in ? vme_types_pkg::S_IDLE : next_state;
  end

  // Cycle attributes are frozen when the address phase is claimed.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      claim_block <= 1'b0;
      claim_mblt  <= 1'b0;
      claim_chain <= 1'b0;
      claim_read  <= 1'b0;
    end else if (state == vme_types_pkg::S_IDLE && trigger) begin
      claim_block <= block_kind;
      claim_mblt  <= mblt_kind;
      claim_chain <= chain_hit;
      claim_read  <= write_n_s | !iack_n_s;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      berr_flag <= 1'b0;
    end else if (state == vme_types_pkg::S_BUF || state == vme_types_pkg::S_BUF2) begin
      berr_flag <= !fifo_valid;
    end else if (state == vme_types_pkg::S_IDLE || state == vme_types_pkg::S_WAIT_DS) begin
      berr_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      vme_d_out <= 32'h0000_0000;
    end else if (state == vme_types_pkg::S_IDLE && trigger && !iack_n_s) begin
      vme_d_out <= {24'h00_0000, irq_vector_in};
    end else if (state == vme_types_pkg::S_REG && reg_ack_in) begin
      vme_d_out <= reg_rdata_in;
    end else if (pop && (state == vme_types_pkg::S_BUF2 || !claim_mblt)) begin
      vme_d_out <= tag_word(claim_chain, fifo_data);
    end
  end

  // The first word of a 64-bit beat rides on the address lines and LWORD.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      {vme_a_out, vme_lword_n_out} <= 32'h0000_0000;
    end else if (pop && state == vme_types_pkg::S_BUF && claim_mblt) begin
      {vme_a_out, vme_lword_n_out} <= tag_word(claim_chain, fifo_data);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_req_out    <= 1'b0;
      reg_write_out  <= 1'b0;
      reg_wide_out   <= 1'b0;
      reg_offset_out <= 16'h0000;
      reg_wdata_out  <= 32'h0000_0000;
    end else begin
      reg_req_out <= (state == vme_types_pkg::S_IDLE) && (next_state == vme_types_pkg::S_REG);
      if (state == vme_types_pkg::S_IDLE && next_state == vme_types_pkg::S_REG) begin
        reg_write_out  <= !write_n_s;
        reg_wide_out   <= !lword_n_s;
        reg_offset_out <= {a_s[15:1], 1'b0};
        reg_wdata_out  <= d_s;
      end
    end
  end

  // The request follows the stored event count, so a buffer read withdraws it.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_active       <= 1'b0;
      vme_irq_oe_n_out <= 7'h7F;
    end else begin
      irq_active       <= (event_trigger_in != 6'h00) && (irq_level_in != 3'h0)
                          && (fifo_count >= event_trigger_in);
      vme_irq_oe_n_out <= irq_active ? ~7'(7'h01 << (irq_level_in - 3'h1)) : 7'h7F;
    end
  end

  assign vme_irq_n_out      = 7'h00;
  assign vme_dtack_n_out    = 1'b0;
  assign vme_berr_n_out     = 1'b0;
  assign vme_dtack_oe_n_out = !(in_ack && !berr_flag);
  assign vme_berr_oe_n_out  = !(in_ack && berr_flag);
  assign vme_d_oe_n_out     = !(in_ack && claim_read && !berr_flag);
  assign vme_a_oe_n_out     = !(in_ack && claim_read && claim_mblt && !berr_flag);
  assign vme_lword_oe_n_out = vme_a_oe_n_out;
  assign vme_iackout_n_out  = !(state == vme_types_pkg::S_PASS);

  event_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (ev_valid_in),
    .in_ready_out  (ev_ready_out),
    .in_data_in    (ev_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_data),
    .count_out     (fifo_count)
  );

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  unknown_am_a:
    assert property (state == vme_types_pkg::S_IDLE && trigger && iack_n_s
                     && kind == vme_types_pkg::CYC_NONE |=> state == vme_types_pkg::S_END
                     ##1 vme_dtack_oe_n_out)
    else $error("Unknown modifier was not ignored.");

  a24_single_a:
    assert property (state == vme_types_pkg::S_IDLE && trigger && iack_n_s && lword_n_s
                     && (am_s == 6'h3D || am_s == 6'h39) && a_s[23:16] == base_addr[7:0]
                     && a_s[15:12] != 4'h0 && !chain_hit |=> reg_req_out)
    else $error("A24 single register cycle not taken.");

  a32_single_a:
    assert property (state == vme_types_pkg::S_IDLE && trigger && iack_n_s && lword_n_s
                     && (am_s == 6'h0D || am_s == 6'h09) && a_s[31:16] == base_addr
                     && a_s[15:12] != 4'h0 && !chain_hit |=> reg_req_out)
    else $error("A32 single register cycle not taken.");

  base_source_a:
    assert property (state == vme_types_pkg::S_IDLE && trigger && base_src_sel_in && lword_n_s
                     && am_s == 6'h0D && a_s[31:16] == {base_high_in, base_low_in} && iack_n_s
                     && a_s[15:12] != 4'h0 && !chain_hit |=> reg_req_out)
    else $error("Programmed base address not selected.");

  block_reg_a:
    assert property (state == vme_types_pkg::S_IDLE && trigger && iack_n_s && block_kind
                     && a_s[15:12] != 4'h0 && !chain_hit |=> state == vme_types_pkg::S_END)
    else $error("Block cycle reached the registers.");

  reg_answer_a:
    assert property (state == vme_types_pkg::S_REG && reg_ack_in
                     |=> !vme_dtack_oe_n_out && vme_d_out == $past(reg_rdata_in))
    else $error("Register answer not presented.");

  dtack_release_a:
    assert property (in_ack && ds_none |=> vme_dtack_oe_n_out && vme_d_oe_n_out)
    else $error("Acknowledge held after strobes released.");

  irq_follow_a:
    assert property (fifo_count == 6'h00 |-> ##2 vme_irq_oe_n_out == 7'h7F)
    else $error("Interrupt held with an empty buffer.");

  chain_tag_a:
    assert property (pop && claim_chain && !claim_mblt |=> vme_d_out[31:27]
                     == $past(slot_position_address_in))
    else $error("Chained word lacks slot position.");
endmodule

// File: testbench/vme_master_model.sv
// Purpose: Backplane master that runs one whole transfer per call.
// Assumes: Pins change at the falling clock edge; answers are read after the rising edge.
// Notes:   Released lines show inverted values, so a stale value never passes as a match.
`timescale 1ns/100ps
module vme_master_model (
  // Clock
  input  wire logic        clk_in,
  // Resolved lines
  input  wire logic [31:1] a_in,
  input  wire logic        lword_n_in,
  input  wire logic [31:0] d_in,
  input  wire logic        dtack_oe_n_in,
  input  wire logic        berr_oe_n_in,
  // Lines driven by the master
  output logic      [31:1] a_out,
  output logic             lword_n_out,
  output logic      [5:0]  am_out,
  output logic             as_n_out,
  output logic             ds_n_out,
  output logic             write_n_out,
  output logic      [31:0] d_out
);
  initial begin
    {a_out, lword_n_out, am_out, d_out} = '0;
    {as_n_out, ds_n_out, write_n_out} = 3'b111;
  end

  // The whole address goes out at once, 24- or 32-bit wide.
  task automatic xfer(input logic [5:0] am, input logic [31:0] adr, input logic wr,
                      input logic lw_n, input logic [31:0] wd,
                      output logic ack, output logic err, output logic [63:0] rd);
    int n;
    n = 0;
    @(negedge clk_in);
    am_out = am;
    a_out = adr[31:1];
    lword_n_out = lw_n;
    write_n_out = ~wr;
    d_out = wd;
    as_n_out = 1'b0;
    ds_n_out = 1'b0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (n < 30 && dtack_oe_n_in === 1'b1 && berr_oe_n_in === 1'b1);
    ack = (dtack_oe_n_in === 1'b0);
    err = (berr_oe_n_in === 1'b0);
    rd = {a_in, lword_n_in, d_in};
    @(negedge clk_in);
    as_n_out = 1'b1;
    ds_n_out = 1'b1;
    a_out = ~a_out;
    d_out = ~d_out;
    // The slave lets go three edges after it sees the strobes high.
    repeat (6) @(negedge clk_in);
  endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the backplane slave front end.
// Assumes: Register bank answers one cycle after each request.
// Notes:   Event words are predicted by a queue; one chained read and one empty-buffer read close the run.
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:1] m_a, s_a;
  logic m_lw, s_lw, a_oe_n, lw_oe_n, as_n, ds_n, wr_n, d_oe_n, dt_oe_n, be_oe_n;
  logic [31:0] m_d, s_d, rwd, rdat, ev_d;
  logic [5:0] am, trig;
  logic [7:1] irq_oe_n;
  logic sel, req, rwr, rwide, rack, ev_v, ev_r, ack, err, cf, iack_n;
  logic [15:0] sw, roff;
  logic [7:0] bhi, blo, caddr, vec;
  logic [4:0] slot;
  logic [2:0] lvl;
  logic [63:0] rd;
  logic [31:0] seed = 32'h0001_4F38;
  logic [31:0] q[$];
  int n_fail = 0;
  int n_compared = 0;
  localparam logic [5:0] SGL[5] = '{6'h3D, 6'h39, 6'h2F, 6'h0D, 6'h09};
  localparam logic [5:0] DRN[12] = '{6'h3F, 6'h3B, 6'h0F, 6'h0B, 6'h3D, 6'h39,
                                      6'h0D, 6'h09, 6'h3C, 6'h38, 6'h0C, 6'h08};
  wire logic [31:1] a_w = a_oe_n ? m_a : s_a;
  wire logic lw_w = lw_oe_n ? m_lw : s_lw;
  wire logic [31:0] d_w = d_oe_n ? m_d : s_d;

  always #12.5 sys_clk_in = ~sys_clk_in;

  vme_master_model mm (.clk_in(sys_clk_in), .a_in(a_w), .lword_n_in(lw_w), .d_in(d_w),
    .dtack_oe_n_in(dt_oe_n), .berr_oe_n_in(be_oe_n), .a_out(m_a), .lword_n_out(m_lw),
    .am_out(am), .as_n_out(as_n), .ds_n_out(ds_n), .write_n_out(wr_n), .d_out(m_d));

  vme_slave_address_decode dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .vme_a_in(a_w), .vme_a_out(s_a), .vme_a_oe_n_out(a_oe_n), .vme_lword_n_in(lw_w),
    .vme_lword_n_out(s_lw), .vme_lword_oe_n_out(lw_oe_n), .vme_am_in(am),
    .vme_as_n_in(as_n), .vme_ds0_n_in(ds_n), .vme_ds1_n_in(ds_n), .vme_write_n_in(wr_n),
    .vme_iack_n_in(iack_n), .vme_iackin_n_in(iack_n), .vme_iackout_n_out(),
    .vme_d_in(d_w), .vme_d_out(s_d), .vme_d_oe_n_out(d_oe_n), .vme_dtack_n_out(),
    .vme_dtack_oe_n_out(dt_oe_n), .vme_berr_n_out(), .vme_berr_oe_n_out(be_oe_n),
    .vme_irq_n_out(), .vme_irq_oe_n_out(irq_oe_n), .base_src_sel_in(sel),
    .rotary_sw_in(sw), .base_high_in(bhi), .base_low_in(blo), .chain_addr_in(caddr),
    .chain_first_in(cf), .chain_last_in(1'b0), .slot_position_address_in(slot),
    .irq_level_in(lvl), .irq_vector_in(vec), .event_trigger_in(trig),
    .reg_req_out(req), .reg_write_out(rwr), .reg_wide_out(rwide), .reg_offset_out(roff),
    .reg_wdata_out(rwd), .reg_ack_in(rack), .reg_rdata_in(rdat),
    .ev_valid_in(ev_v), .ev_ready_out(ev_r), .ev_data_in(ev_d));

  // Register bank stand-in: data is a fixed function of the offset.
  always @(negedge sys_clk_in) begin
    rack <= req;
    rdat <= {16'h0000, roff ^ 16'hA5A5};
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ad(input logic [5:0] c, input logic [15:0] off);
    logic [15:0] b;
    b = sel ? {bhi, blo} : sw;
    return (c[5:4] == 2'b00) ? {b, off} : {8'h00, b[7:0], off};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    test_done();
  end

  initial begin
    {sel, cf, ev_v, ev_d} = '0;
    iack_n = 1'b1;
    sw = 16'(xs());
    {bhi, blo, caddr, vec} = xs();
    slot = 5'(xs());
    lvl = 3'(1 + xs() % 7);
    trig = 6'h02;
    repeat (6) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    foreach (SGL[i]) begin
      mm.xfer(SGL[i], ad(SGL[i], 16'h1002 + 16'(2 * i)), 1'b0, 1'b1, '0, ack, err, rd);
      check("reg ack", 32'(ack), 1);
      check("reg data", rd[15:0], (16'h1002 + 16'(2 * i)) ^ 16'hA5A5);
    end
    mm.xfer(6'h0D, ad(6'h0D, 16'h1010), 1'b1, 1'b0, seed, ack, err, rd);
    check("wr fields", {ack, rwr, rwide, roff}, {3'b111, 16'h1010});
    check("wr data", rwd, seed);
    mm.xfer(6'h3E, ad(6'h3D, 16'h1000), 1'b0, 1'b1, '0, ack, err, rd);
    check("bad am", 32'(ack), 0);
    mm.xfer(6'h0D, {sw ^ 16'h0001, 16'h1000}, 1'b0, 1'b1, '0, ack, err, rd);
    check("bad base", 32'(ack), 0);
    mm.xfer(6'h0F, ad(6'h0F, 16'h1000), 1'b0, 1'b0, '0, ack, err, rd);
    check("blk reg", 32'(ack), 0);
    sel = 1'b1;
    bhi = sw[15:8] ^ 8'h5A;
    mm.xfer(6'h0D, ad(6'h0D, 16'h1004), 1'b0, 1'b1, '0, ack, err, rd);
    check("ader ack", 32'(ack), 1);
    mm.xfer(6'h0D, {sw, 16'h1004}, 1'b0, 1'b1, '0, ack, err, rd);
    check("sw unused", 32'(ack), 0);
    sel = 1'b0;
    for (int n = 0; n < 40 && ev_r === 1'b1; n++) begin
      @(negedge sys_clk_in);
      ev_v = ev_r;
      ev_d = xs();
      if (ev_r === 1'b1) q.push_back(ev_d);
    end
    @(negedge sys_clk_in);
    ev_v = 1'b0;
    check("fill", {ev_r, 31'(q.size())}, 32);
    repeat (3) @(negedge sys_clk_in);
    check("irq on", 32'(irq_oe_n), 32'(7'h7F ^ (7'h01 << (lvl - 1))));
    iack_n = 1'b0;
    mm.xfer(6'h3D, {28'h000_0000, lvl, 1'b0}, 1'b0, 1'b1, '0, ack, err, rd);
    iack_n = 1'b1;
    check("iack ack", 32'(ack), 1);
    check("iack vector", rd[31:0], {24'h00_0000, vec});
    for (int j = 0; q.size() > 0 && j < 40; j++) begin
      mm.xfer(DRN[j % 12], ad(DRN[j % 12], 16'h0000), 1'b0, 1'b0, '0, ack, err, rd);
      check("buf ack", 32'(ack), 1);
      if (DRN[j % 12][1:0] == 2'b00) check("mblt hi", rd[63:32], q.pop_front());
      check("buf data", rd[31:0], q.pop_front());
    end
    check("irq off", 32'(irq_oe_n), 32'h7F);
    cf = 1'b1;
    @(negedge sys_clk_in);
    ev_v = 1'b1;
    ev_d = xs();
    @(negedge sys_clk_in);
    ev_v = 1'b0;
    mm.xfer(6'h0F, {caddr, 24'h00_0000}, 1'b0, 1'b0, '0, ack, err, rd);
    cf = 1'b0;
    check("chain ack", 32'(ack), 1);
    check("chain data", rd[31:0], {slot, ev_d[26:0]});
    mm.xfer(6'h0F, ad(6'h0F, 16'h0000), 1'b0, 1'b0, '0, ack, err, rd);
    check("empty", {ack, err}, 2'b01);
    test_done();
  end
endmodule
